//--- logic/rhd_pkg.sv
// constants shared by the range hint command decoder
`default_nettype none

package rhd_pkg;

    // ====
    // command dword fields
    localparam int          RANGE_CNT_LSB     = 0;
    localparam int          RANGE_CNT_W       = 8;
    localparam int          DEALLOC_BIT       = 2;
    localparam int          WR_SET_BIT        = 1;
    localparam int          RD_SET_BIT        = 0;

    // ====
    // range entry layout
    localparam int          ENTRY_BYTES       = 16;
    localparam int          DWORDS_PER_ENTRY  = 4;
    localparam int          MAX_RANGES        = 256;
    localparam int          LIST_BYTES        = 4096;
    localparam int          PAGE_BYTES        = 4096;
    localparam logic [1:0]  DW_CTX            = 2'h0;
    localparam logic [1:0]  DW_LEN            = 2'h1;
    localparam logic [1:0]  DW_SLBA_LO        = 2'h2;
    localparam logic [1:0]  DW_SLBA_HI        = 2'h3;

    // ====
    // context attribute fields
    localparam int          ACC_SIZE_LSB      = 24;
    localparam int          ACC_SIZE_W        = 8;
    localparam int          WP_BIT            = 10;
    localparam int          SEQ_WR_BIT        = 9;
    localparam int          SEQ_RD_BIT        = 8;
    localparam int          LAT_LSB           = 4;
    localparam int          LAT_W             = 2;
    localparam int          FREQ_LSB          = 0;
    localparam int          FREQ_W            = 4;
    localparam logic [3:0]  FREQ_NONE         = 4'h0;
    localparam logic [3:0]  FREQ_LAST_DEFINED = 4'h5;
    localparam logic [1:0]  LAT_NONE          = 2'h0;
    localparam logic [1:0]  LAT_IDLE          = 2'h1;
    localparam logic [1:0]  LAT_NORMAL        = 2'h2;
    localparam logic [1:0]  LAT_LOW           = 2'h3;

    // ====
    // completion status
    localparam logic [7:0]  STATUS_OK         = 8'h00;
    localparam logic [7:0]  STATUS_CONFLICT   = 8'h80;

    // ====
    // software registers
    localparam int          REG_ADDR_W        = 8;
    localparam logic [7:0]  REG_CTRL          = 8'h00;
    localparam logic [7:0]  REG_STATUS        = 8'h04;
    localparam logic [7:0]  REG_CMD_CNT       = 8'h08;
    localparam logic [7:0]  REG_RANGE_CNT     = 8'h0C;
    localparam int          CTRL_ENABLE_BIT   = 0;
    localparam int          CTRL_HINTS_BIT    = 1;
    localparam logic [1:0]  CTRL_RESET        = 2'h3;
    localparam int          STAT_BUSY_BIT     = 0;
    localparam int          STAT_CODE_LSB     = 8;
    localparam int          CNT_W             = 16;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_EMIT,
        ST_CPL
    } rhd_state_t;

endpackage

`default_nettype wire

//--- logic/rhd_addr_gen.sv
// byte address of a list offset across the one allowed page break
`default_nettype none

module rhd_addr_gen #(
    parameter int PAGE_BYTES = rhd_pkg::PAGE_BYTES
) (
    input  wire logic [63:0] dptr1_in,
    input  wire logic [63:0] dptr2_in,
    input  wire logic [11:0] offset_in,
    output logic      [63:0] addr_out,
    output logic             second_page_out
);
    import rhd_pkg::*;

    localparam int PW = $clog2(PAGE_BYTES);

    logic [PW:0] room;
    logic [PW:0] off_ext;

    always_comb begin
        room    = (PW+1)'(PAGE_BYTES) - {1'b0, dptr1_in[PW-1:0]};
        off_ext = (PW+1)'(offset_in);
        // (R20) switch pointer at break
        if (off_ext < room) begin
            second_page_out = 1'b0;
            addr_out        = dptr1_in + 64'(off_ext);
        end else begin
            second_page_out = 1'b1;
            addr_out        = dptr2_in + 64'(off_ext - room);
        end
    end

endmodule

`default_nettype wire

//--- logic/rhd_attr_decode.sv
// splits one context attribute dword into its hint fields
`default_nettype none

module rhd_attr_decode (
    input  wire logic [31:0] ctx_in,
    input  wire logic        apply_in,
    output logic      [7:0]  acc_size_out,
    output logic             write_prepare_out,
    output logic             seq_write_hint_out,
    output logic             seq_read_hint_out,
    output logic      [1:0]  latency_hint_out,
    output logic      [3:0]  frequency_hint_out
);
    import rhd_pkg::*;

    logic [3:0] freq_raw;

    always_comb begin
        freq_raw = ctx_in[FREQ_LSB +: FREQ_W];
        // (R10) hints optional, may be off
        if (!apply_in) begin
            acc_size_out       = 8'h00;
            write_prepare_out  = 1'b0;
            seq_write_hint_out = 1'b0;
            seq_read_hint_out  = 1'b0;
            latency_hint_out   = LAT_NONE;
            frequency_hint_out = FREQ_NONE;
        end else begin
            // (R12) access size, zero means none
            acc_size_out       = ctx_in[ACC_SIZE_LSB +: ACC_SIZE_W];
            // (R13) write prepare flag
            write_prepare_out  = ctx_in[WP_BIT];
            // (R14) sequential write flag
            seq_write_hint_out = ctx_in[SEQ_WR_BIT];
            // (R15) sequential read flag
            seq_read_hint_out  = ctx_in[SEQ_RD_BIT];
            // (R16) latency code passed as is
            latency_hint_out   = ctx_in[LAT_LSB +: LAT_W];
            // (R17) reserved frequency codes read as none
            frequency_hint_out = (freq_raw > FREQ_LAST_DEFINED) ?
                                 FREQ_NONE : freq_raw;
        end
    end

endmodule

`default_nettype wire

//--- logic/rhd_decoder.sv
// range hint command decoder: fetches range list, emits hints, completes
//
// Operation
// (R01) uses only both pointers and dwords 10, 11
// (R02) 64-bit first pointer; list has at most one break
// (R03) second pointer continues list; never a list pointer
// (R04) dword 10 bits 7:0 zero-based range count
// (R05) dword 11 bit 2 allows deallocating all ranges
// (R06) dword 11 bit 1: whole set one unit for writes
// (R07) dword 11 bit 0: whole set one unit for reads
// (R08) entry: attributes, length, starting block
// (R09) up to 256 entries in 4096 bytes
// (R10) acting on attributes is optional
// (R11) data stays intact whatever the hints
// (R12) bits 31:24 blocks per command, zero none
// (R13) bit 10 range written soon
// (R14) bit 9 sequential write as one object
// (R15) bit 8 sequential read as one object
// (R16) bits 5:4 latency: none, idle, normal, lowest
// (R17) bits 3:0 frequency; codes above 5 reserved
// (R18) post completion; 80h reports conflicting attributes
// (R19) deallocated blocks read stable; protection all ones
// (R20) fetch count plus one entries; switch pointer at break
`default_nettype none

module rhd_decoder #(
    parameter int PAGE_BYTES = rhd_pkg::PAGE_BYTES
) (
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_in,
    // command
    input  wire logic                          cmd_valid_in,
    output logic                               cmd_ready_out,
    input  wire logic [63:0]                   cmd_dptr1_in,
    input  wire logic [63:0]                   cmd_dptr2_in,
    input  wire logic [31:0]                   cmd_dw10_in,
    input  wire logic [31:0]                   cmd_dw11_in,
    // list fetch
    output logic                               fetch_req_out,
    output logic      [63:0]                   fetch_addr_out,
    input  wire logic                          fetch_ack_in,
    input  wire logic [31:0]                   fetch_data_in,
    // range hints
    output logic                               range_valid_out,
    input  wire logic                          range_ready_in,
    output logic      [7:0]                    range_index_out,
    output logic      [63:0]                   range_slba_out,
    output logic      [31:0]                   range_len_out,
    output logic                               range_dealloc_out,
    output logic                               whole_set_write_hint_out,
    output logic                               whole_set_read_hint_out,
    output logic      [7:0]                    acc_size_out,
    output logic                               write_prepare_out,
    output logic                               seq_write_hint_out,
    output logic                               seq_read_hint_out,
    output logic      [1:0]                    latency_hint_out,
    output logic      [3:0]                    frequency_hint_out,
    // completion
    output logic                               cpl_valid_out,
    input  wire logic                          cpl_ready_in,
    output logic      [7:0]                    cpl_status_out,
    // registers
    input  wire logic [rhd_pkg::REG_ADDR_W-1:0] reg_addr_in,
    input  wire logic [31:0]                   reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic      [31:0]                   reg_rdata_out
);
    import rhd_pkg::*;

    // ====
    // state
    rhd_state_t       state_q,    state_d;
    logic [63:0]      dptr1_q,    dptr1_d;
    logic [63:0]      dptr2_q,    dptr2_d;
    logic [7:0]       last_q,     last_d;
    logic [2:0]       set_q,      set_d;
    logic [9:0]       dw_q,       dw_d;
    logic             req_q,      req_d;
    logic [63:0]      faddr_q,    faddr_d;
    logic [63:0]      slba_q,     slba_d;
    logic [31:0]      len_q,      len_d;
    logic [7:0]       acc_q,      acc_d;
    logic [2:0]       flags_q,    flags_d;
    logic [1:0]       lat_q,      lat_d;
    logic [3:0]       freq_q,     freq_d;
    logic [7:0]       status_q,   status_d;
    logic [1:0]       ctrl_q,     ctrl_d;
    logic [CNT_W-1:0] cmd_cnt_q,  cmd_cnt_d;
    logic [CNT_W-1:0] rng_cnt_q,  rng_cnt_d;
    logic [31:0]      rdata_q,    rdata_d;

    logic [63:0]      gen_addr;
    logic [7:0]       dec_acc;
    logic             dec_wp;
    logic             dec_sw;
    logic             dec_sr;
    logic [1:0]       dec_lat;
    logic [3:0]       dec_freq;
    logic             conflict;

    rhd_addr_gen #(
        .PAGE_BYTES      (PAGE_BYTES)
    ) u_addr (
        .dptr1_in        (dptr1_d),
        .dptr2_in        (dptr2_d),
        .offset_in       ({dw_d, 2'b00}),
        .addr_out        (gen_addr),
        .second_page_out ()
    );

    // decoded from the live fetch word so results land in flops
    rhd_attr_decode u_attr (
        .ctx_in             (fetch_data_in),
        .apply_in           (ctrl_q[CTRL_HINTS_BIT]),
        .acc_size_out       (dec_acc),
        .write_prepare_out  (dec_wp),
        .seq_write_hint_out (dec_sw),
        .seq_read_hint_out  (dec_sr),
        .latency_hint_out   (dec_lat),
        .frequency_hint_out (dec_freq)
    );

    // a set claimed both to be dropped and read back whole is contradictory
    assign conflict = cmd_dw11_in[DEALLOC_BIT] & cmd_dw11_in[RD_SET_BIT];

    // ====
    // command sequencer
    always_comb begin
        state_d   = state_q;
        dptr1_d   = dptr1_q;
        dptr2_d   = dptr2_q;
        last_d    = last_q;
        set_d     = set_q;
        dw_d      = dw_q;
        req_d     = req_q;
        slba_d    = slba_q;
        len_d     = len_q;
        acc_d     = acc_q;
        flags_d   = flags_q;
        lat_d     = lat_q;
        freq_d    = freq_q;
        status_d  = status_q;
        cmd_cnt_d = cmd_cnt_q;
        rng_cnt_d = rng_cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_valid_in && ctrl_q[CTRL_ENABLE_BIT]) begin
                    // (R01) only pointers and dwords 10, 11 taken
                    dptr1_d = cmd_dptr1_in;
                    // (R03) continuation pointer held for the break
                    dptr2_d = cmd_dptr2_in;
                    // (R04) zero-based count, upper bits dropped
                    last_d  = cmd_dw10_in[RANGE_CNT_LSB +: RANGE_CNT_W];
                    // (R05) (R06) (R07) whole-set attributes
                    set_d   = {cmd_dw11_in[DEALLOC_BIT],
                               cmd_dw11_in[WR_SET_BIT],
                               cmd_dw11_in[RD_SET_BIT]};
                    dw_d    = 10'h000;
                    if (conflict) begin
                        // (R18) conflicting attributes, nothing fetched
                        status_d = STATUS_CONFLICT;
                        state_d  = ST_CPL;
                    end else begin
                        status_d = STATUS_OK;
                        req_d    = 1'b1;
                        state_d  = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                if (fetch_ack_in) begin
                    // (R08) place each dword of the entry
                    case (dw_q[1:0])
                        DW_CTX: begin
                            acc_d   = dec_acc;
                            flags_d = {dec_wp, dec_sw, dec_sr};
                            lat_d   = dec_lat;
                            freq_d  = dec_freq;
                        end
                        DW_LEN:     len_d          = fetch_data_in;
                        DW_SLBA_LO: slba_d[31:0]   = fetch_data_in;
                        DW_SLBA_HI: slba_d[63:32]  = fetch_data_in;
                        default:    len_d          = len_q;
                    endcase
                    if (dw_q[1:0] == DW_SLBA_HI) begin
                        req_d   = 1'b0;
                        state_d = ST_EMIT;
                    end else begin
                        dw_d = dw_q + 10'h001;
                    end
                end
            end
            ST_EMIT: begin
                if (range_ready_in) begin
                    rng_cnt_d = rng_cnt_q + 16'h0001;
                    // (R09) list ends at index last_q, at most 256 entries, one 4 KiB list
                    if (dw_q[9:2] == last_q) begin
                        state_d = ST_CPL;
                    end else begin
                        // (R20) next entry in order
                        dw_d    = dw_q + 10'h001;
                        req_d   = 1'b1;
                        state_d = ST_FETCH;
                    end
                end
            end
            ST_CPL: begin
                // (R18) completion posted until taken
                if (cpl_ready_in) begin
                    cmd_cnt_d = cmd_cnt_q + 16'h0001;
                    state_d   = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // (R20) address follows the pointer split
        faddr_d = gen_addr;
    end

    // ====
    // register port
    always_comb begin
        ctrl_d  = ctrl_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr_in && reg_addr_in == REG_CTRL) begin
            ctrl_d = reg_wdata_in[1:0];
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CTRL:      rdata_d = {30'h0, ctrl_q};
                REG_STATUS: begin
                    rdata_d[STAT_BUSY_BIT] = (state_q != ST_IDLE);
                    rdata_d[STAT_CODE_LSB +: 8] = status_q;
                end
                REG_CMD_CNT:   rdata_d = {16'h0000, cmd_cnt_q};
                REG_RANGE_CNT: rdata_d = {16'h0000, rng_cnt_q};
                default:       rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q   <= ST_IDLE;
            dptr1_q   <= 64'h0;
            dptr2_q   <= 64'h0;
            last_q    <= 8'h00;
            set_q     <= 3'h0;
            dw_q      <= 10'h000;
            req_q     <= 1'b0;
            faddr_q   <= 64'h0;
            slba_q    <= 64'h0;
            len_q     <= 32'h0;
            acc_q     <= 8'h00;
            flags_q   <= 3'h0;
            lat_q     <= 2'h0;
            freq_q    <= 4'h0;
            status_q  <= 8'h00;
            ctrl_q    <= CTRL_RESET;
            cmd_cnt_q <= 16'h0000;
            rng_cnt_q <= 16'h0000;
            rdata_q   <= 32'h0000_0000;
        end else begin
            state_q   <= state_d;
            dptr1_q   <= dptr1_d;
            dptr2_q   <= dptr2_d;
            last_q    <= last_d;
            set_q     <= set_d;
            dw_q      <= dw_d;
            req_q     <= req_d;
            faddr_q   <= faddr_d;
            slba_q    <= slba_d;
            len_q     <= len_d;
            acc_q     <= acc_d;
            flags_q   <= flags_d;
            lat_q     <= lat_d;
            freq_q    <= freq_d;
            status_q  <= status_d;
            ctrl_q    <= ctrl_d;
            cmd_cnt_q <= cmd_cnt_d;
            rng_cnt_q <= rng_cnt_d;
            rdata_q   <= rdata_d;
        end
    end

    // ====
    // outputs
    assign cmd_ready_out  = (state_q == ST_IDLE) && ctrl_q[CTRL_ENABLE_BIT];
    assign fetch_req_out  = req_q;
    assign fetch_addr_out = faddr_q;
    assign range_valid_out = (state_q == ST_EMIT);
    assign range_index_out = dw_q[9:2];
    assign range_slba_out  = slba_q;
    assign range_len_out   = len_q;
    // (R05) (R19) deallocation is only permission; the media side keeps
    // deallocated blocks stable and protection fields all ones
    assign range_dealloc_out        = set_q[2];
    assign whole_set_write_hint_out = set_q[1];
    assign whole_set_read_hint_out  = set_q[0];
    // (R11) hints are advisory outputs only, never a data path
    assign acc_size_out       = acc_q;
    assign write_prepare_out  = flags_q[2];
    assign seq_write_hint_out = flags_q[1];
    assign seq_read_hint_out  = flags_q[0];
    assign latency_hint_out   = lat_q;
    assign frequency_hint_out = freq_q;
    assign cpl_valid_out  = (state_q == ST_CPL);
    assign cpl_status_out = status_q;
    assign reg_rdata_out  = rdata_q;

endmodule

`default_nettype wire

//--- tb/rhd_list_mem.sv
// host memory model serving range list dwords to the decoder
`default_nettype none

module rhd_list_mem (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        slow_in,
    input  wire logic        req_in,
    input  wire logic [63:0] addr_in,
    output logic             ack_out,
    output logic      [31:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned wait_q;

    // list contents are a fixed scramble of the byte address
    function automatic logic [31:0] mem_word(logic [63:0] a);
        return ((a[31:0] ^ (a[31:0] >> 5)) * 32'h9E37_79B1) ^ a[63:32];
    endfunction

    always @(posedge sys_clk_in) begin
        ack_out <= 1'b0;
        // released data lines never keep the last word
        data_out <= ~data_out;
        if (rst_in) begin
            data_out <= 32'h0;
            wait_q <= 0;
        end else if (req_in && !ack_out) begin
            if (wait_q == 0) begin
                ack_out <= 1'b1;
                data_out <= mem_word(addr_in);
                wait_q <= slow_in ? $urandom_range(4) : 0;
            end else begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule

`default_nettype wire

//--- tb/rhd_decoder_chk.sv
// concurrent checks on the range hint decoder ports
`default_nettype none

module rhd_decoder_chk (
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic        cmd_valid_in,
    input wire logic        cmd_ready_out,
    input wire logic [63:0] cmd_dptr1_in,
    input wire logic [31:0] cmd_dw11_in,
    input wire logic        fetch_req_out,
    input wire logic [63:0] fetch_addr_out,
    input wire logic        fetch_ack_in,
    input wire logic        range_valid_out,
    input wire logic        range_ready_in,
    input wire logic [7:0]  range_index_out,
    input wire logic [63:0] range_slba_out,
    input wire logic [31:0] range_len_out,
    input wire logic [3:0]  frequency_hint_out,
    input wire logic        cpl_valid_out,
    input wire logic        cpl_ready_in,
    input wire logic [7:0]  cpl_status_out,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import rhd_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic take, bad;
    assign take = cmd_valid_in && cmd_ready_out;
    assign bad = cmd_dw11_in[DEALLOC_BIT] && cmd_dw11_in[RD_SET_BIT];

    // ====
    // command and completion
    chk_first_fetch:
    assert property (take && !bad |=> fetch_req_out &&
        fetch_addr_out == $past(cmd_dptr1_in)) else $error("bad first fetch");
    chk_conflict_cpl:
    assert property (take && bad |=> cpl_valid_out && !fetch_req_out &&
        cpl_status_out == STATUS_CONFLICT) else $error("bad conflict");
    chk_busy_refuse:
    assert property (fetch_req_out || range_valid_out || cpl_valid_out
        |-> !cmd_ready_out) else $error("ready while busy");
    chk_cpl_hold:
    assert property (cpl_valid_out && !cpl_ready_in |=> cpl_valid_out &&
        $stable(cpl_status_out)) else $error("completion dropped");
    chk_cpl_drop:
    assert property (cpl_valid_out && cpl_ready_in |=> !cpl_valid_out)
        else $error("completion repeated");

    // ====
    // list fetch; holds for 16-byte aligned lists only
    chk_fetch_hold:
    assert property (fetch_req_out && !fetch_ack_in |=> fetch_req_out &&
        $stable(fetch_addr_out)) else $error("fetch request moved");
    chk_dword_step:
    assert property (fetch_req_out && fetch_ack_in &&
        fetch_addr_out[3:2] != 2'h3 |=> fetch_req_out &&
        fetch_addr_out == $past(fetch_addr_out) + 64'h4)
        else $error("dword order wrong");
    chk_entry_done:
    assert property (fetch_req_out && fetch_ack_in &&
        fetch_addr_out[3:2] == 2'h3 |=> !fetch_req_out && range_valid_out)
        else $error("entry not emitted");
    chk_range_hold:
    assert property (range_valid_out && !range_ready_in |=> range_valid_out
        && $stable({range_slba_out, range_len_out})) else $error("range moved");
    chk_freq_code:
    assert property (range_valid_out |-> frequency_hint_out <=
        FREQ_LAST_DEFINED) else $error("reserved frequency passed");
    chk_rdata_quiet:
    assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data without read");

    cover property (take && bad);
    cover property (fetch_ack_in && fetch_addr_out[11:0] == 12'hFFC);
    cover property (range_valid_out && range_index_out == 8'hFF);
endmodule

bind rhd_decoder rhd_decoder_chk chk_u (.*);

`default_nettype wire

//--- tb/rhd_decoder_tb.sv
// random command stream bench for the range hint decoder
`default_nettype none

module range_hint_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rhd_pkg::*;
    logic sys_clk_in, rst_in, cmd_valid_in, cmd_ready_out, fetch_req_out;
    logic fetch_ack_in, range_valid_out, range_ready_in, range_dealloc_out;
    logic whole_set_write_hint_out, whole_set_read_hint_out, slow;
    logic write_prepare_out, seq_write_hint_out, seq_read_hint_out;
    logic cpl_valid_out, cpl_ready_in, reg_wr_in, reg_rd_in;
    logic [63:0] cmd_dptr1_in, cmd_dptr2_in, fetch_addr_out, range_slba_out;
    logic [31:0] cmd_dw10_in, cmd_dw11_in, fetch_data_in, range_len_out;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    logic [7:0]  range_index_out, acc_size_out, cpl_status_out, reg_addr_in;
    logic [1:0]  latency_hint_out;
    logic [3:0]  frequency_hint_out;
    int          err_count, compares, n_cmd, n_rng, i;

    rhd_decoder dut_u (.*);
    rhd_list_mem mdl_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .slow_in(slow), .req_in(fetch_req_out), .addr_in(fetch_addr_out),
        .ack_out(fetch_ack_in), .data_out(fetch_data_in));

    always #5 sys_clk_in = ~sys_clk_in;
    // consumers stall at random
    always @(posedge sys_clk_in) begin
        range_ready_in <= 1'($urandom_range(1));
        cpl_ready_in <= 1'($urandom_range(1));
    end

    // ====
    // checking and closing
    task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_ev(int s);
        for (int k = 0; k < 400; k++) begin
            @(negedge sys_clk_in);
            if (s == 0 ? cmd_ready_out : s == 1 ?
                range_valid_out & range_ready_in :
                cpl_valid_out & cpl_ready_in) return;
        end
        err_count++;
        $display("BAD wait%0d exp 1 seen 0", s);
        report_and_stop();
    endtask

    // ====
    // register port
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a, logic [31:0] e, string w);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        chk(w, reg_rdata_out, e);
    endtask

    // ====
    // expectations
    function automatic logic [63:0] ex_addr(logic [63:0] p1, p2, int off);
        int rem;
        rem = PAGE_BYTES - int'(p1[11:0]);
        return off < rem ? p1 + 64'(off) : p2 + 64'(off - rem);
    endfunction
    function automatic logic [16:0] ex_hint(logic [31:0] c, logic on);
        if (!on) return 17'h0;
        return {c[31:24], c[10:8], c[5:4], c[3:0] > 4'h5 ? 4'h0 : c[3:0]};
    endfunction

    task automatic run_cmd(logic [63:0] p1, p2, logic [31:0] w10, w11,
                           logic h);
        logic [31:0] d [4];
        int j, r;
        reg_wr(REG_CTRL, {30'h0, h, 1'b1});
        @(posedge sys_clk_in);
        {cmd_dptr1_in, cmd_dptr2_in, cmd_dw10_in, cmd_dw11_in} <=
            {p1, p2, w10, w11};
        cmd_valid_in <= 1'b1;
        wait_ev(0);
        @(posedge sys_clk_in);
        cmd_valid_in <= 1'b0;
        // dealloc together with whole-set read fetches nothing
        for (r = 0; r <= w10[7:0] && !(w11[2] && w11[0]); r++) begin
            for (j = 0; j < 4; j++)
                d[j] = mdl_u.mem_word(ex_addr(p1, p2, 16 * r + 4 * j));
            wait_ev(1);
            chk("index", range_index_out, 64'(r));
            chk("slba", range_slba_out, {d[3], d[2]});
            chk("length", range_len_out, d[1]);
            chk("flags", {range_dealloc_out, whole_set_write_hint_out,
                whole_set_read_hint_out}, w11[2:0]);
            chk("hints", {acc_size_out, write_prepare_out, seq_write_hint_out,
                seq_read_hint_out, latency_hint_out, frequency_hint_out},
                ex_hint(d[0], h));
            @(posedge sys_clk_in);
            n_rng++;
        end
        wait_ev(2);
        chk("status", cpl_status_out, (w11[2] && w11[0]) ?
            STATUS_CONFLICT : STATUS_OK);
        @(posedge sys_clk_in);
        n_cmd++;
    endtask

    initial begin
        void'($urandom(32'hF888));
        {sys_clk_in, cmd_valid_in, reg_wr_in, reg_rd_in, slow} = '0;
        {cmd_dptr1_in, cmd_dptr2_in, cmd_dw10_in, cmd_dw11_in} = '0;
        {reg_addr_in, reg_wdata_in} = '0;
        {err_count, compares, n_cmd, n_rng} = '0;
        rst_in = 1'b1;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        reg_rd(REG_CTRL, 32'h3, "ctrl reset");
        reg_rd(REG_CMD_CNT, 32'h0, "count reset");
        reg_wr(8'h40, 32'hFFFF_FFFF);
        reg_rd(8'h40, 32'h0, "unmapped");
        $display("test registers done");
        run_cmd(64'h1_2F00, 64'h7_0000, 32'hFF, 32'h0, 1'b1);
        run_cmd(64'hFF0, 64'h9_3000, 32'hFFFF_FF00, 32'hFFFF_FFFA, 1'b1);
        run_cmd(64'h3000, 64'h0, 32'h4, 32'h5, 1'b1);
        reg_rd(REG_STATUS, 32'h8000, "status");
        $display("test corners done");
        for (i = 0; i < 24; i++) begin
            slow <= 1'($urandom_range(1));
            run_cmd({32'h0, $urandom} & ~64'hF, {$urandom, 20'h0, 12'h0},
                32'({$urandom, 3'h0, 5'($urandom)}), $urandom,
                1'($urandom_range(1)));
        end
        reg_rd(REG_CMD_CNT, 32'(n_cmd), "commands");
        reg_rd(REG_RANGE_CNT, 32'(n_rng), "ranges");
        $display("test random done");
        reg_wr(REG_CTRL, 32'h0);
        cmd_valid_in <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk("refused", {cmd_ready_out, fetch_req_out}, 64'h0);
        cmd_valid_in <= 1'b0;
        $display("test disable done");
        report_and_stop();
    end
endmodule

`default_nettype wire
